//--- hw/trg_pkg.sv
// constants and types for the true random byte generator
package trg_pkg;
    // register byte offsets
    localparam logic [11:0] OFF_TASK_START   = 12'h000;
    localparam logic [11:0] OFF_TASK_STOP    = 12'h004;
    localparam logic [11:0] OFF_EVENT_READY  = 12'h100;
    localparam logic [11:0] OFF_SHORTCUT     = 12'h200;
    localparam logic [11:0] OFF_IRQ_EN_SET   = 12'h304;
    localparam logic [11:0] OFF_IRQ_EN_CLR   = 12'h308;
    localparam logic [11:0] OFF_BIAS_CONFIG  = 12'h504;
    localparam logic [11:0] OFF_RANDOM_OUT   = 12'h508;

    // field positions
    localparam int TASK_BIT     = 0;
    localparam int EVENT_BIT    = 0;
    localparam int STOP_SC_BIT  = 0;
    localparam int IRQ_RDY_BIT  = 0;
    localparam int BIAS_EN_BIT  = 0;
    localparam int VALUE_W      = 8;

    // reset values
    localparam logic [VALUE_W-1:0] VALUE_RST = 8'h00;
    localparam logic               CFG_RST   = 1'b0;

    // timing
    localparam int CLK_MHZ          = 125;
    localparam int START_DELAY_US   = 128;
    localparam int START_DELAY_CYC  = START_DELAY_US * CLK_MHZ;
    localparam int RAW_BYTE_NS      = 30000;
    localparam int CLK_PERIOD_NS    = 8;
    localparam int BIT_CYC          =
        RAW_BYTE_NS / (CLK_PERIOD_NS * VALUE_W);
    localparam int BIT_CNT_W        = 9;
    localparam int DLY_CNT_W        = 16;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_WARMUP = 2'b01,
        ST_RUN    = 2'b10
    } trg_state_t;

    // software settings
    typedef struct packed {
        logic stop_on_ready;
        logic bias_en;
        logic irq_en;
    } trg_cfg_t;
endpackage

//--- hw/trg_random_generator.sv
// random byte generator core with apb register slave
`timescale 1ns/1ps
`default_nettype none

module trg_random_generator #(
    parameter int START_DELAY = trg_pkg::START_DELAY_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        noise_bit,
    output logic             value_ready_pulse,
    output logic             running,
    output logic             irq
);

    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] off);
        hit = (a[11:2] == off[11:2]);
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        mapped = hit(a, trg_pkg::OFF_TASK_START)
              || hit(a, trg_pkg::OFF_TASK_STOP)
              || hit(a, trg_pkg::OFF_EVENT_READY)
              || hit(a, trg_pkg::OFF_SHORTCUT)
              || hit(a, trg_pkg::OFF_IRQ_EN_SET)
              || hit(a, trg_pkg::OFF_IRQ_EN_CLR)
              || hit(a, trg_pkg::OFF_BIAS_CONFIG)
              || hit(a, trg_pkg::OFF_RANDOM_OUT);
    endfunction

    localparam logic [trg_pkg::DLY_CNT_W-1:0] DLY_LAST =
        trg_pkg::DLY_CNT_W'(START_DELAY - 1);
    localparam logic [trg_pkg::BIT_CNT_W-1:0] BIT_LAST =
        trg_pkg::BIT_CNT_W'(trg_pkg::BIT_CYC - 1);

    trg_pkg::trg_state_t              state_q;
    trg_pkg::trg_state_t              state_d;
    trg_pkg::trg_cfg_t                cfg_q;
    logic [trg_pkg::DLY_CNT_W-1:0]    dly_cnt_q;
    logic [trg_pkg::BIT_CNT_W-1:0]    bit_cnt_q;
    logic [trg_pkg::VALUE_W-1:0]      shift_q;
    logic [2:0]                       fill_q;
    logic [trg_pkg::VALUE_W-1:0]      value_q;
    logic                             event_q;
    logic                             pair_have_q;
    logic                             pair_first_q;
    logic                             pulse_q;
    logic [31:0]                      prdata_q;
    logic                             err_q;

    logic wr_acc;
    logic rd_setup;
    logic start_task;
    logic stop_task;
    logic sample_tick;
    logic bit_valid;
    logic bit_value;
    logic byte_done;
    logic event_clr;

    // apb: zero wait states, data captured in setup phase
    // pslverr only for unmapped words; writes there are dropped
    assign wr_acc   = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign pready   = 1'b1;
    assign prdata   = prdata_q;
    assign pslverr  = err_q && penable;

    assign start_task = wr_acc
        && hit(paddr, trg_pkg::OFF_TASK_START)
        && pwdata[trg_pkg::TASK_BIT];
    logic sw_stop;
    logic auto_stop;
    logic warm_done;

    assign sw_stop = wr_acc
        && hit(paddr, trg_pkg::OFF_TASK_STOP)
        && pwdata[trg_pkg::TASK_BIT];
    // shortcut stop lands on the edge that loads the byte
    assign auto_stop = byte_done && cfg_q.stop_on_ready;
    assign stop_task = sw_stop || auto_stop;
    assign warm_done = (dly_cnt_q == DLY_LAST);
    assign event_clr = wr_acc
        && hit(paddr, trg_pkg::OFF_EVENT_READY)
        && !pwdata[trg_pkg::EVENT_BIT];

    // sequencer: idle, warm-up once per start, then run
    // a start while busy is ignored
    always_comb begin
        state_d = state_q;
        case (state_q)
            trg_pkg::ST_IDLE: begin
                if (start_task) begin
                    state_d = trg_pkg::ST_WARMUP;
                end
            end
            trg_pkg::ST_WARMUP: begin
                if (stop_task) begin
                    state_d = trg_pkg::ST_IDLE;
                end else if (warm_done) begin
                    state_d = trg_pkg::ST_RUN;
                end
            end
            trg_pkg::ST_RUN: begin
                if (stop_task) begin
                    state_d = trg_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = trg_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= trg_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign running = (state_q == trg_pkg::ST_RUN);

    // one-time warm-up count, only after start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_cnt_q <= '0;
        end else if (state_q == trg_pkg::ST_WARMUP) begin
            dly_cnt_q <= dly_cnt_q + 1'b1;
        end else begin
            dly_cnt_q <= '0;
        end
    end

    // noise sampling interval
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_q <= '0;
        end else if (!running || sample_tick) begin
            bit_cnt_q <= '0;
        end else begin
            bit_cnt_q <= bit_cnt_q + 1'b1;
        end
    end

    assign sample_tick = running && (bit_cnt_q == BIT_LAST);

    // bias correction on bit pairs: 01 -> 0, 10 -> 1, equal dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pair_have_q  <= 1'b0;
            pair_first_q <= 1'b0;
        end else if (!running || !cfg_q.bias_en) begin
            pair_have_q  <= 1'b0;
            pair_first_q <= 1'b0;
        end else if (sample_tick) begin
            pair_have_q  <= !pair_have_q;
            pair_first_q <= noise_bit;
        end
    end

    // pair decode: 01 -> 0, 10 -> 1; equal pairs carry no bit
    function automatic logic [1:0] pair_decode(input logic first,
                                               input logic second);
        case ({first, second})
            2'b01:   pair_decode = 2'b10;
            2'b10:   pair_decode = 2'b11;
            default: pair_decode = 2'b00;
        endcase
    endfunction

    logic [1:0] pair_bits;

    always_comb begin
        pair_bits = pair_decode(pair_first_q, noise_bit);
        if (cfg_q.bias_en) begin
            bit_valid = sample_tick && pair_have_q
                     && pair_bits[1];
            bit_value = pair_bits[0];
        end else begin
            bit_valid = sample_tick;
            bit_value = noise_bit;
        end
    end

    // byte assembly, first sampled bit ends in the top bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_q <= '0;
        end else if (!running) begin
            shift_q <= '0;
        end else if (bit_valid) begin
            shift_q <= {shift_q[trg_pkg::VALUE_W-2:0], bit_value};
        end
    end

    // bit count of the byte; a stop drops the partial byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fill_q <= '0;
        end else if (!running) begin
            fill_q <= '0;
        end else if (bit_valid) begin
            fill_q <= fill_q + 1'b1;
        end
    end

    assign byte_done = bit_valid && (fill_q == 3'h7);

    logic [trg_pkg::VALUE_W-1:0] value_d;

    // the finishing bit goes straight into the output word
    assign value_d = {shift_q[trg_pkg::VALUE_W-2:0], bit_value};

    // output value, overwritten by each new byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_q <= trg_pkg::VALUE_RST;
        end else if (byte_done) begin
            value_q <= value_d;
        end
    end

    // event flag: set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_q <= 1'b0;
        end else if (byte_done) begin
            event_q <= 1'b1;
        end else if (event_clr) begin
            event_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= byte_done;
        end
    end

    assign value_ready_pulse = pulse_q;

    // software settings: shortcut bit, bias enable, irq enable
    // irq enable is set and cleared through separate words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q.stop_on_ready <= 1'b0;
        end else if (wr_acc && hit(paddr, trg_pkg::OFF_SHORTCUT)) begin
            cfg_q.stop_on_ready <= pwdata[trg_pkg::STOP_SC_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q.bias_en <= trg_pkg::CFG_RST;
        end else if (wr_acc && hit(paddr, trg_pkg::OFF_BIAS_CONFIG)) begin
            cfg_q.bias_en <= pwdata[trg_pkg::BIAS_EN_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q.irq_en <= 1'b0;
        end else if (wr_acc && hit(paddr, trg_pkg::OFF_IRQ_EN_SET)
                     && pwdata[trg_pkg::IRQ_RDY_BIT]) begin
            cfg_q.irq_en <= 1'b1;
        end else if (wr_acc && hit(paddr, trg_pkg::OFF_IRQ_EN_CLR)
                     && pwdata[trg_pkg::IRQ_RDY_BIT]) begin
            cfg_q.irq_en <= 1'b0;
        end
    end

    assign irq = event_q && cfg_q.irq_en;

    // register index of an offset: bits [1:0] are not decoded
    function automatic logic [9:0] word_of(input logic [11:0] off);
        word_of = off[11:2];
    endfunction

    // read word from register state, zero in unused bits
    logic [31:0] rd_word;

    always_comb begin
        rd_word = '0;
        case (paddr[11:2])
            word_of(trg_pkg::OFF_EVENT_READY): begin
                rd_word[trg_pkg::EVENT_BIT] = event_q;
            end
            word_of(trg_pkg::OFF_SHORTCUT): begin
                rd_word[trg_pkg::STOP_SC_BIT] = cfg_q.stop_on_ready;
            end
            word_of(trg_pkg::OFF_IRQ_EN_SET): begin
                rd_word[trg_pkg::IRQ_RDY_BIT] = cfg_q.irq_en;
            end
            word_of(trg_pkg::OFF_IRQ_EN_CLR): begin
                rd_word[trg_pkg::IRQ_RDY_BIT] = cfg_q.irq_en;
            end
            word_of(trg_pkg::OFF_BIAS_CONFIG): begin
                rd_word[trg_pkg::BIAS_EN_BIT] = cfg_q.bias_en;
            end
            word_of(trg_pkg::OFF_RANDOM_OUT): begin
                rd_word[trg_pkg::VALUE_W-1:0] = value_q;
            end
            default: begin
                rd_word = '0;
            end
        endcase
    end

    // read data captured in setup phase, held through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (rd_setup) begin
            if (!pwrite) begin
                prdata_q <= rd_word;
            end else begin
                prdata_q <= '0;
            end
        end
    end

    // unmapped address flagged for the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_q <= 1'b0;
        end else if (rd_setup) begin
            err_q <= !mapped(paddr);
        end
    end

endmodule

`default_nettype wire

//--- testbench/trg_random_generator_chk.sv
// port assertions for the random byte generator
`timescale 1ns/1ps
`default_nettype none
module trg_random_generator_chk #(
    parameter int START_DELAY = trg_pkg::START_DELAY_CYC
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        noise_bit,
    input wire logic        value_ready_pulse,
    input wire logic        running,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable && pwrite;
    sequence start_wr;
        acc && paddr == 12'h000 && pwdata[0] && !running;
    endsequence
    sequence stop_wr;
        acc && paddr == 12'h004 && pwdata[0];
    endsequence
    sequence load_seen;
        value_ready_pulse;
    endsequence
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("access without ready");
    a_err_access: assert property (pslverr |-> psel && penable)
        else $error("error outside access");
    a_pulse_single: assert property (
        value_ready_pulse |=> !value_ready_pulse) else $error("long pulse");
    a_pulse_running: assert property (
        value_ready_pulse |-> $past(running, 2)) else $error("idle pulse");
    a_start_warmup: assert property (
        start_wr |=> !running [*8]) else $error("no warm-up");
    a_stop_halts: assert property (
        stop_wr |=> !running) else $error("still running");
    a_stop_quiet: assert property (
        stop_wr |-> ##3 !value_ready_pulse [*8]) else $error("pulse after stop");
    a_irq_cause: assert property (
        $rose(irq) |-> ($past(acc && paddr == 12'h304 && pwdata[0])
        or load_seen)) else $error("irq without cause");
    a_event_clear: assert property (
        acc && paddr == 12'h100 && !pwdata[0]
        |=> !irq || value_ready_pulse)
        else $error("irq after clear");
    a_irq_disable: assert property (
        acc && paddr == 12'h308 && pwdata[0] |=> !irq)
        else $error("irq after disable");
endmodule
bind trg_random_generator trg_random_generator_chk #(
    .START_DELAY(START_DELAY)
) chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .noise_bit(noise_bit),
    .value_ready_pulse(value_ready_pulse), .running(running), .irq(irq));
`default_nettype wire

//--- testbench/true_random_byte_generator_tb_top.sv
// self-checking bench for the random byte generator
`timescale 1ns/1ps
`default_nettype none
module true_random_byte_generator_tb_top;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        noise_bit = 1, pready, pslverr, value_ready_pulse;
    logic        running, irq, err, got;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int          bad_count = 0, compares = 0;
    always #4 pclk = ~pclk;
    trg_random_generator #(.START_DELAY(20)) trg_random_generator_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .noise_bit(noise_bit),
        .value_ready_pulse(value_ready_pulse), .running(running), .irq(irq));
    task give_verdict;
        if (bad_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        if (n >= 50) begin
            bad_count++;
            give_verdict();
        end
        @(negedge pclk);
    endtask
    // got tells whether a pulse came within lim cycles
    task wait_pulse(input int lim);
        got = 0;
        for (int i = 0; i < lim && !got; i++) begin
            @(posedge pclk);
            got = (value_ready_pulse === 1'b1);
        end
        @(negedge pclk);
    endtask
    task t_reset;
        apb(0, 12'h200, 0); check(rd, 0);
        apb(0, 12'h304, 0); check(rd, 0);
        apb(0, 12'h504, 0); check(rd, 0);
        apb(0, 12'h508, 0); check(rd, 0);
        apb(0, 12'h0fc, 0); check(err, 1);
    endtask
    task t_run;
        apb(1, 12'h000, 1);
        wait_pulse(5000); check(got, 1);
        check(running, 1);
        apb(0, 12'h508, 0); check(rd, 32'h0000_00ff);
        apb(0, 12'h100, 0); check(rd, 1);
        check(irq, 0);
        apb(1, 12'h304, 1); check(irq, 1);
        @(posedge pclk) noise_bit <= 0;
        apb(1, 12'h100, 0); check(irq, 0);
        wait_pulse(4500); check(got, 1);
        check(irq, 1);
        apb(0, 12'h508, 0); check(rd, 0);
        apb(1, 12'h308, 1); check(irq, 0);
        apb(0, 12'h304, 0); check(rd, 0);
        apb(1, 12'h004, 1); check(running, 0);
        wait_pulse(4000); check(got, 0);
        apb(0, 12'h508, 0); check(rd, 0);
        apb(1, 12'h100, 0);
    endtask
    task t_shortcut;
        apb(1, 12'h200, 1);
        @(posedge pclk) noise_bit <= 1;
        apb(1, 12'h000, 1);
        wait_pulse(5000); check(got, 1);
        check(running, 0);
        wait_pulse(4000); check(got, 0);
        apb(1, 12'h508, 32'h5a); apb(0, 12'h508, 0);
        check(rd, 32'h0000_00ff);
        apb(1, 12'h200, 0);
        apb(1, 12'h100, 0);
    endtask
    task t_bias;
        apb(1, 12'h504, 1); apb(0, 12'h504, 0); check(rd, 1);
        apb(1, 12'h000, 1);
        wait_pulse(9000); check(got, 0);
        check(running, 1);
        apb(1, 12'h004, 1);
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        t_reset();
        t_run();
        t_shortcut();
        t_bias();
        give_verdict();
    end
endmodule
`default_nettype wire
